// [src/rrse_consts.vh]
// Offsets, field layouts, operation codes and reset values for the return/rotate/sleep core
`ifndef RRSE_CONSTS_VH
`define RRSE_CONSTS_VH
// ==========================================
// Register byte offsets
`define RRSE_OFS_CMD     8'h00
`define RRSE_OFS_STATUS  8'h04
`define RRSE_OFS_ACC     8'h08
`define RRSE_OFS_PC      8'h0C
`define RRSE_OFS_STACK   8'h10
`define RRSE_OFS_FADDR   8'h14
`define RRSE_OFS_FDATA   8'h18
`define RRSE_OFS_WATCHDOG 8'h1C
`define RRSE_OFS_INTCTL  8'h20
// ==========================================
// Command word fields
`define RRSE_CMD_OP      2:0
`define RRSE_CMD_DEST    3
`define RRSE_CMD_FADDR   10:4
`define RRSE_CMD_LIT     23:16
// ==========================================
// Status word bit positions
`define RRSE_ST_BUSY     0
`define RRSE_ST_CARRY    1
`define RRSE_ST_EXPIRY   2
`define RRSE_ST_HALT     3
`define RRSE_ST_SLEEP    4
`define RRSE_ST_IRQEN    5
`define RRSE_INTCTL_IRQEN 7
// ==========================================
// Operation select codes
`define RRSE_OP_NOP      3'h0
`define RRSE_OP_RETINT   3'h1
`define RRSE_OP_RETLIT   3'h2
`define RRSE_OP_RETURN   3'h3
`define RRSE_OP_ROTL     3'h4
`define RRSE_OP_ROTR     3'h5
`define RRSE_OP_SLEEP    3'h6
// ==========================================
// Widths, reset values, timing
`define RRSE_PC_W        13
`define RRSE_STK_AW      3
`define RRSE_ICYC_DIV    2'h3
`define RRSE_RST_STATUS  8'h00
`define RRSE_RST_EXPIRY  1'h1
`define RRSE_RST_HALT    1'h1
`endif

// [src/rrse_core.v]
// Return, rotate-through-carry and sleep execution core with APB register access
// Function
// [RULE_01] Interrupt return pops stack, loads PC, two cycles
// [RULE_02] Interrupt return sets global interrupt enable bit
// [RULE_03] Literal return loads accumulator with 8-bit literal
// [RULE_04] Literal return reloads PC, two cycles, flags kept
// [RULE_05] Subroutine return pops into PC, two cycles
// [RULE_06] Rotate left file register through carry
// [RULE_07] Rotate left destination: 0 accumulator, 1 file
// [RULE_08] Rotate right file register through carry
// [RULE_09] Rotate right destination: 0 accumulator, 1 file
// [RULE_10] Sleep clears watchdog counter and its prescaler
// [RULE_11] Sleep sets expiry flag, clears halt flag
// [RULE_12] Sleep then halts the oscillator
// [RULE_13] Carry takes shifted-out bit, vacated bit takes carry
// [RULE_14] Rotates take one cycle, change only carry
//
// The APB slave port and the register offsets were chosen for this implementation.
`include "rrse_consts.vh"
module rrse_core (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output wire        pready,
   output reg         pslverr,
   output wire        osc_halted,
   output wire        global_irq_enable
);
   // ==========================================
   // Declarations
   // Register words, unused bits read zero:
   //   CMD      op, destination, file address, literal; a write starts it
   //   STATUS   busy, carry, expiry, halt, sleep, interrupt enable
   //   ACC      accumulator; PC program counter
   //   STACK    a write pushes; a read gives top entry and pointer
   //   FADDR    file address for indirect access; FDATA that file register
   //   WATCHDOG counter and prescaler; any write clears both
   //   INTCTL   interrupt control, bit 7 the global enable
   // Operation codes: 0 none, 1 interrupt return, 2 literal return,
   //   3 return, 4 rotate left, 5 rotate right, 6 sleep, 7 none

   // Sequencer states
   localparam ST_IDLE  = 2'h0;
   localparam ST_EXEC1 = 2'h1;
   localparam ST_EXEC2 = 2'h2;

   // Sequencer and latched command
   reg  [1:0]            state_r;
   reg  [2:0]            op_r;
   reg                   dest_r;
   reg  [6:0]            faddr_r;
   reg  [7:0]            lit_r;
   // Architectural registers
   reg  [7:0]            acc_r;
   reg                   carry_r;
   reg                   expiry_flag_r;
   reg                   halt_flag_r;
   reg                   sleep_r;
   reg  [7:0]            intctl_r;
   reg  [`RRSE_PC_W-1:0] pc_r;
   // Watchdog, bus file pointer and file registers
   reg  [7:0]            watchdog_counter_r;
   reg  [7:0]            watchdog_pre_r;
   reg  [6:0]            fsel_r;
   reg  [7:0]            file_mem [0:127];
   // Combinational results
   reg  [7:0]            rot_res;
   reg                   rot_carry;
   reg  [31:0]           rd_mux;
   reg                   err_mux;

   // Decode and interconnect
   wire                  icyc_en;
   wire                  busy;
   wire                  setup_ph;
   wire                  wr_acc;
   wire                  exec_now;
   wire                  is_ret;
   wire                  is_rot;
   wire                  stk_push;
   wire                  stk_pop;
   wire [`RRSE_PC_W-1:0] stack_top;
   wire [`RRSE_STK_AW-1:0] stack_ptr;
   wire [7:0]            fsrc;
   wire [7:0]            status_word;

   // ==========================================
   // Instruction clock and stack
   // The divider freezes while asleep, and the watchdog with it
   rrse_icyc_div u_div (
      .pclk     (pclk),
      .presetn  (presetn),
      .osc_halt (sleep_r),
      .icyc_en  (icyc_en)
   );

   // Only bus writes push; calls are modelled by software
   rrse_stack u_stack (
      .pclk      (pclk),
      .presetn   (presetn),
      .push      (stk_push),
      .pop       (stk_pop),
      .push_data (pwdata[`RRSE_PC_W-1:0]),
      .stack_top (stack_top),
      .stack_ptr (stack_ptr)
   );

   // ==========================================
   // Decode of the pending operation
   // Codes 0 and 7 fall through as no-ops that only step the PC
   assign busy     = (state_r != ST_IDLE);
   assign exec_now = (state_r == ST_EXEC1) && icyc_en;
   assign is_ret   = (op_r == `RRSE_OP_RETINT) || (op_r == `RRSE_OP_RETLIT)
                  || (op_r == `RRSE_OP_RETURN);
   assign is_rot   = (op_r == `RRSE_OP_ROTL) || (op_r == `RRSE_OP_ROTR);
   assign stk_pop  = exec_now && is_ret;   // [RULE_01] [RULE_05]
   assign fsrc     = file_mem[faddr_r];

   // Carry acts as a ninth bit of the rotation
   // Both directions share the one file read port
   always @* begin
      if (op_r == `RRSE_OP_ROTL) begin
         rot_res   = {fsrc[6:0], carry_r};   // [RULE_06] [RULE_13]
         rot_carry = fsrc[7];                // [RULE_13]
      end else begin
         rot_res   = {carry_r, fsrc[7:1]};   // [RULE_08] [RULE_13]
         rot_carry = fsrc[0];                // [RULE_13]
      end
   end

   // ==========================================
   // APB handshake: zero wait states, read data captured in setup
   assign setup_ph = psel && !penable;
   assign wr_acc   = psel && penable && pwrite && !pslverr;
   assign pready   = 1'b1;
   assign stk_push = wr_acc && (paddr == `RRSE_OFS_STACK) && !busy;

   // Status word: busy, carry, expiry, halt, sleep, interrupt enable
   assign status_word = {2'h0, intctl_r[`RRSE_INTCTL_IRQEN], sleep_r,
                         halt_flag_r, expiry_flag_r, carry_r, busy};

   // Read mux and refusal decision for the access being set up
   always @* begin
      rd_mux  = 32'h0;
      err_mux = 1'b0;
      case (paddr)
         `RRSE_OFS_CMD: begin
            rd_mux  = {8'h0, lit_r, 5'h0, faddr_r, dest_r, op_r};
            err_mux = pwrite && (busy || sleep_r);  // Command refused while running or asleep
         end
         `RRSE_OFS_STATUS: begin
            rd_mux = {24'h0, status_word};
         end
         `RRSE_OFS_ACC: begin
            rd_mux = {24'h0, acc_r};
         end
         `RRSE_OFS_PC: begin
            rd_mux = {19'h0, pc_r};
         end
         `RRSE_OFS_STACK: begin
            rd_mux  = {16'h0, stack_top, 3'h0} | {29'h0, stack_ptr};
            err_mux = pwrite && busy;
         end
         `RRSE_OFS_FADDR: begin
            rd_mux = {25'h0, fsel_r};
         end
         `RRSE_OFS_FDATA: begin
            rd_mux = {24'h0, file_mem[fsel_r]};
         end
         `RRSE_OFS_WATCHDOG: begin
            rd_mux = {16'h0, watchdog_pre_r, watchdog_counter_r};
         end
         `RRSE_OFS_INTCTL: begin
            rd_mux = {24'h0, intctl_r};
         end
         default: begin
            err_mux = 1'b1;  // Unmapped offset
         end
      endcase
   end

   // Read data and error come from flops set in the setup cycle
   // Writes read back zero, so no stale word leaks onto the bus
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0;
         pslverr <= 1'b0;
      end else if (setup_ph) begin
         prdata  <= pwrite ? 32'h0 : rd_mux;
         pslverr <= err_mux;
      end
   end

   // ==========================================
   // Sequencer: a command waits for the next instruction cycle
   // A refused command never lands, since an error masks the access
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= ST_IDLE;
         op_r    <= `RRSE_OP_NOP;
         dest_r  <= 1'b0;
         faddr_r <= 7'h0;
         lit_r   <= 8'h0;
      end else begin
         if (wr_acc && (paddr == `RRSE_OFS_CMD)) begin
            op_r    <= pwdata[`RRSE_CMD_OP];
            dest_r  <= pwdata[`RRSE_CMD_DEST];
            faddr_r <= pwdata[`RRSE_CMD_FADDR];
            lit_r   <= pwdata[`RRSE_CMD_LIT];
            state_r <= ST_EXEC1;
         end else if (exec_now) begin
            // Returns spend a second cycle on the flushed fetch
            state_r <= is_ret ? ST_EXEC2 : ST_IDLE;  // [RULE_01] [RULE_04] [RULE_05] [RULE_14]
         end else if ((state_r == ST_EXEC2) && icyc_en) begin
            state_r <= ST_IDLE;
         end
      end
   end

   // ==========================================
   // Architectural state: execution overrides a same-cycle bus write
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc_r         <= 8'h0;
         carry_r       <= 1'b0;
         sleep_r       <= 1'b0;
         intctl_r      <= 8'h0;
         pc_r          <= {`RRSE_PC_W{1'b0}};
         fsel_r        <= 7'h0;
      end else begin
         // Bus writes first; an execution in the same cycle overrides them
         if (wr_acc) begin
            case (paddr)
               `RRSE_OFS_STATUS: begin
                  carry_r <= pwdata[`RRSE_ST_CARRY];
                  // Writing zero to the sleep bit is the wake-up
                  if (!pwdata[`RRSE_ST_SLEEP]) begin
                     sleep_r <= 1'b0;
                  end
               end
               `RRSE_OFS_ACC: begin
                  acc_r <= pwdata[7:0];
               end
               `RRSE_OFS_PC: begin
                  if (!busy) begin
                     pc_r <= pwdata[`RRSE_PC_W-1:0];
                  end
               end
               `RRSE_OFS_FADDR: begin
                  fsel_r <= pwdata[6:0];
               end
               `RRSE_OFS_INTCTL: begin
                  intctl_r <= pwdata[7:0];
               end
               default: begin
               end
            endcase
         end
         // Execution of the pending operation
         if (exec_now) begin
            case (op_r)
               `RRSE_OP_RETINT: begin
                  pc_r                         <= stack_top;  // [RULE_01]
                  intctl_r[`RRSE_INTCTL_IRQEN] <= 1'b1;       // [RULE_02]
               end
               `RRSE_OP_RETLIT: begin
                  acc_r <= lit_r;      // [RULE_03]
                  pc_r  <= stack_top;  // [RULE_04]
               end
               `RRSE_OP_RETURN: begin
                  pc_r <= stack_top;   // [RULE_05]
               end
               `RRSE_OP_ROTL, `RRSE_OP_ROTR: begin
                  carry_r <= rot_carry;               // [RULE_13] [RULE_14]
                  if (!dest_r) begin
                     acc_r <= rot_res;                // [RULE_07] [RULE_09]
                  end
                  pc_r <= pc_r + 1'b1;
               end
               `RRSE_OP_SLEEP: begin
                  sleep_r       <= 1'b1;  // [RULE_12]
                  pc_r          <= pc_r + 1'b1;
               end
               default: begin
                  pc_r <= pc_r + 1'b1;
               end
            endcase
         end
      end
   end

   // ==========================================
   // Power flags: only the sleep operation changes them
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         expiry_flag_r <= `RRSE_RST_EXPIRY;
         halt_flag_r   <= `RRSE_RST_HALT;
      end else if (exec_now && (op_r == `RRSE_OP_SLEEP)) begin
         expiry_flag_r <= 1'b1;  // [RULE_11]
         halt_flag_r   <= 1'b0;  // [RULE_11]
      end
   end

   // ==========================================
   // Watchdog: prescaler counts instruction cycles, counter its wraps
   // A bus write to the watchdog word is software's periodic clear
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         watchdog_counter_r <= 8'h0;
         watchdog_pre_r     <= 8'h0;
      end else if (exec_now && (op_r == `RRSE_OP_SLEEP)) begin
         watchdog_counter_r <= 8'h0;  // [RULE_10]
         watchdog_pre_r     <= 8'h0;  // [RULE_10]
      end else if (wr_acc && (paddr == `RRSE_OFS_WATCHDOG)) begin
         watchdog_counter_r <= 8'h0;
         watchdog_pre_r     <= 8'h0;
      end else if (icyc_en) begin
         watchdog_pre_r <= watchdog_pre_r + 8'h1;
         if (watchdog_pre_r == 8'hFF) begin
            watchdog_counter_r <= watchdog_counter_r + 8'h1;
         end
      end
   end

   // ==========================================
   // File registers: a rotate write-back wins over a bus write
   // Contents are not reset; software writes before it reads
   always @(posedge pclk) begin
      if (exec_now && is_rot && dest_r) begin
         file_mem[faddr_r] <= rot_res;  // [RULE_07] [RULE_09]
      end else if (wr_acc && (paddr == `RRSE_OFS_FDATA)) begin
         file_mem[fsel_r] <= pwdata[7:0];
      end
   end

   // ==========================================
   // Outputs
   // Both come straight from flops, so no glitch reaches the pins
   assign osc_halted        = sleep_r;                        // [RULE_12]
   assign global_irq_enable = intctl_r[`RRSE_INTCTL_IRQEN];   // [RULE_02]
endmodule // rrse_core

// [src/rrse_icyc_div.v]
// Instruction cycle enable divider, stopped while the oscillator is halted
`include "rrse_consts.vh"
module rrse_icyc_div (
   input  wire       pclk,
   input  wire       presetn,
   input  wire       osc_halt,
   output wire       icyc_en
);
   reg [1:0] cnt_r;

   // ==========================================
   // Divide pclk by four; a halted oscillator freezes the count at zero
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r <= 2'h0;
      end else if (osc_halt) begin
         cnt_r <= 2'h0;
      end else begin
         cnt_r <= cnt_r + 2'h1;
      end
   end

   assign icyc_en = !osc_halt && (cnt_r == `RRSE_ICYC_DIV);
endmodule // rrse_icyc_div

// [src/rrse_stack.v]
// Circular return address stack with push and pop
`include "rrse_consts.vh"
module rrse_stack (
   input  wire                    pclk,
   input  wire                    presetn,
   input  wire                    push,
   input  wire                    pop,
   input  wire [`RRSE_PC_W-1:0]   push_data,
   output wire [`RRSE_PC_W-1:0]   stack_top,
   output wire [`RRSE_STK_AW-1:0] stack_ptr
);
   reg [`RRSE_PC_W-1:0]   mem [0:(1<<`RRSE_STK_AW)-1];
   reg [`RRSE_STK_AW-1:0] ptr_r;

   // ==========================================
   // Pointer wraps like the real stack: overflow silently overwrites
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ptr_r <= {`RRSE_STK_AW{1'b0}};
      end else if (push) begin
         ptr_r <= ptr_r + 1'b1;
      end else if (pop) begin
         ptr_r <= ptr_r - 1'b1;
      end
   end

   // Storage needs no reset; contents are undefined until pushed
   always @(posedge pclk) begin
      if (push) begin
         mem[ptr_r] <= push_data;
      end
   end

   assign stack_top = mem[ptr_r - 1'b1];
   assign stack_ptr = ptr_r;
endmodule // rrse_stack

// [verif/return_rotate_sleep_exec_tb_top.sv]
// Self-checking APB testbench for the return/rotate/sleep core
`include "rrse_consts.vh"
`define CHK(act, exp) begin cmp_count++; if ((act) !== (exp)) begin mismatches++; $display("unexpected at %0t: got %h expected %h", $time, act, exp); end end
module return_rotate_sleep_exec_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        pclk    = 1'b0;
   logic        presetn = 1'b0;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic [7:0]  paddr   = 8'h00;
   logic [31:0] pwdata  = 32'h0;
   wire  [31:0] prdata;
   wire         pready;
   wire         pslverr;
   wire         osc_halted;
   wire         global_irq_enable;
   int          mismatches = 0;
   int          cmp_count  = 0;
   // ==========================================
   // Clock, reset and design
   always #5 pclk = ~pclk;
   rrse_core DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .osc_halted(osc_halted), .global_irq_enable(global_irq_enable));
   // ==========================================
   // Bus tasks: request held until pready is seen high at an edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      // Only the hang guard ends a wait that never sees pready
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
      `CHK(e, 1'b0)
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] x);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0, r, e);
      `CHK(r, x)
      `CHK(e, 1'b0)
   endtask
   // Busy bit sampled at a setup edge a fixed distance from the command edge
   task automatic busy_chk(input int n, input logic x);
      logic [31:0] r;
      logic        e;
      repeat (n) @(posedge pclk);
      apb(1'b0, `RRSE_OFS_STATUS, 32'h0, r, e);
      `CHK(r[0], x)
   endtask
   // Two-cycle ops still busy five edges on, idle by nine; one-cycle ops idle by five
   task automatic exec(input logic [31:0] cmd, input logic two);
      wr(`RRSE_OFS_CMD, cmd);
      busy_chk(3, two);
      if (two) busy_chk(1, 1'b0);
   endtask
   task stop_test;
      $display("mismatches=%0d comparisons=%0d", mismatches, cmp_count);
      if (mismatches == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // ==========================================
   // Hang guard, well beyond the few hundred cycles the tests need
   initial begin
      repeat (20000) @(posedge pclk);
      mismatches++;
      stop_test;
   end
   // ==========================================
   // Test sequence
   initial begin
      logic [7:0]  fv [4];
      logic [6:0]  fa [4];
      logic [3:0]  ci;
      logic [31:0] r;
      logic [31:0] pc0;
      logic [7:0]  res;
      logic        co;
      logic        e;
      logic        d;
      fv = '{8'hA5, 8'h4C, 8'h01, 8'h82};
      fa = '{7'h7F, 7'h00, 7'h40, 7'h7F};
      ci = 4'hB;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      rd_chk(`RRSE_OFS_STATUS, 32'h0000000C);
      // Rotates: both directions, both destinations, address bounds
      for (int i = 0; i < 4; i++) begin
         d = i[0];
         res = (i < 2) ? {fv[i][6:0], ci[i]} : {ci[i], fv[i][7:1]};
         co = (i < 2) ? fv[i][7] : fv[i][0];
         wr(`RRSE_OFS_ACC, 32'h5A);
         wr(`RRSE_OFS_FADDR, {25'h0, fa[i]});
         wr(`RRSE_OFS_FDATA, {24'h0, fv[i]});
         wr(`RRSE_OFS_STATUS, {30'h0, ci[i], 1'b0});
         apb(1'b0, `RRSE_OFS_PC, 32'h0, pc0, e);
         exec({21'h0, fa[i], d, (i < 2) ? `RRSE_OP_ROTL : `RRSE_OP_ROTR}, 1'b0);
         rd_chk(`RRSE_OFS_ACC, d ? 32'h5A : {24'h0, res});
         rd_chk(`RRSE_OFS_FDATA, d ? {24'h0, res} : {24'h0, fv[i]});
         rd_chk(`RRSE_OFS_STATUS, {28'h0, 2'h3, co, 1'b0});
         rd_chk(`RRSE_OFS_PC, pc0 + 32'h1);
      end
      // Returns: three pushes, then each return kind pops one
      wr(`RRSE_OFS_STACK, 32'h0123);
      wr(`RRSE_OFS_STACK, 32'h1ABC);
      wr(`RRSE_OFS_STACK, 32'h0F0F);
      rd_chk(`RRSE_OFS_STACK, {16'h0, 13'h0F0F, 3'h3});
      wr(`RRSE_OFS_STATUS, 32'h02);
      exec({29'h0, `RRSE_OP_RETURN}, 1'b1);
      rd_chk(`RRSE_OFS_PC, 32'h0F0F);
      rd_chk(`RRSE_OFS_STACK, {16'h0, 13'h1ABC, 3'h2});
      exec({8'h0, 8'hFF, 13'h0, `RRSE_OP_RETLIT}, 1'b1);
      rd_chk(`RRSE_OFS_ACC, 32'hFF);
      rd_chk(`RRSE_OFS_PC, 32'h1ABC);
      rd_chk(`RRSE_OFS_STATUS, 32'h0E);
      rd_chk(`RRSE_OFS_INTCTL, 32'h00);
      exec({29'h0, `RRSE_OP_RETINT}, 1'b1);
      rd_chk(`RRSE_OFS_PC, 32'h0123);
      rd_chk(`RRSE_OFS_INTCTL, 32'h80);
      `CHK(global_irq_enable, 1'b1)
      rd_chk(`RRSE_OFS_STATUS, 32'h2E);
      // Sleep after the watchdog has had time to count
      repeat (60) @(posedge pclk);
      exec({29'h0, `RRSE_OP_SLEEP}, 1'b0);
      `CHK(osc_halted, 1'b1)
      rd_chk(`RRSE_OFS_WATCHDOG, 32'h0);
      rd_chk(`RRSE_OFS_STATUS, 32'h36);
      repeat (40) @(posedge pclk);
      rd_chk(`RRSE_OFS_WATCHDOG, 32'h0);
      apb(1'b1, `RRSE_OFS_CMD, 32'h0, r, e);
      `CHK(e, 1'b1)
      wr(`RRSE_OFS_STATUS, 32'h02);
      // The wake lands on the access edge; look once it has settled
      @(negedge pclk);
      `CHK(osc_halted, 1'b0)
      rd_chk(`RRSE_OFS_STATUS, 32'h26);
      // Unmapped offset is refused
      apb(1'b0, 8'h24, 32'h0, r, e);
      `CHK(e, 1'b1)
      stop_test;
   end
endmodule // return_rotate_sleep_exec_tb_top

// [verif/rrse_core_monitor.sv]
// Port-level assertion checker for the return/rotate/sleep core
`include "rrse_consts.vh"
module rrse_core_monitor (
   input wire        pclk,
   input wire        presetn,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [7:0]  paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire        pready,
   input wire        pslverr,
   input wire        osc_halted,
   input wire        global_irq_enable
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ==========================================
   // Bus phase sequences
   // Accepted command write at its access edge; refused ones carry an error
   sequence s_cmd_acc(op);
      psel && penable && pwrite && paddr == `RRSE_OFS_CMD && pwdata[2:0] == op && !pslverr;
   endsequence
   sequence s_rd_setup(a);
      psel && !penable && !pwrite && paddr == a;
   endsequence
   // ==========================================
   // Sleep entry and the halted state
   property p_sleep_halts;
      s_cmd_acc(`RRSE_OP_SLEEP) |-> ##[1:5] osc_halted;
   endproperty
   a_sleep_halts: assert property (p_sleep_halts) else $error("oscillator not halted after sleep");
   // Only a wake write through the status register may restart the oscillator
   property p_halt_holds;
      osc_halted && !(psel && penable && pwrite && paddr == `RRSE_OFS_STATUS && !pwdata[4]) |=> osc_halted;
   endproperty
   a_halt_holds: assert property (p_halt_holds) else $error("oscillator restarted without wake");
   property p_refuse_asleep;
      psel && !penable && pwrite && paddr == `RRSE_OFS_CMD && osc_halted |=> pslverr;
   endproperty
   a_refuse_asleep: assert property (p_refuse_asleep) else $error("command accepted while halted");
   property p_watchdog_clear;
      s_rd_setup(`RRSE_OFS_WATCHDOG) ##0 osc_halted |=> prdata[15:0] == 16'h0000;
   endproperty
   a_watchdog_clear: assert property (p_watchdog_clear) else $error("watchdog not clear in sleep");
   // Expiry set, halt cleared, sleep bit set
   property p_sleep_flags;
      s_rd_setup(`RRSE_OFS_STATUS) ##0 osc_halted |=> prdata[4:2] == 3'h5;
   endproperty
   a_sleep_flags: assert property (p_sleep_flags) else $error("sleep flags wrong");
   // ==========================================
   // Global interrupt enable
   property p_intret_irqen;
      s_cmd_acc(`RRSE_OP_RETINT) |-> ##[1:9] global_irq_enable;
   endproperty
   a_intret_irqen: assert property (p_intret_irqen) else $error("interrupt enable not set");
   property p_irqen_holds;
      global_irq_enable && !(psel && penable && pwrite && paddr == `RRSE_OFS_INTCTL) |=> global_irq_enable;
   endproperty
   a_irqen_holds: assert property (p_irqen_holds) else $error("interrupt enable dropped");
   property p_irqen_read;
      s_rd_setup(`RRSE_OFS_INTCTL) |=> prdata[7] == $past(global_irq_enable);
   endproperty
   a_irqen_read: assert property (p_irqen_read) else $error("control bit 7 differs from pin");
endmodule // rrse_core_monitor

bind rrse_core rrse_core_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .osc_halted(osc_halted), .global_irq_enable(global_irq_enable));
